/* File: tb.sv */
`timescale 1ns/1ns
module tb;
  import tmr_ch0_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cen_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] cnt = 16'h0000;
  logic dcnt = 1'b0;
  logic trg = 1'b0;
  logic fin = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, clr_o, rld_o, psc_o, ref_o, main_o, comp_o, poe_o;
  logic brk_o, cmt_o, chi_o, chd_o, upi_o, upd_o;
  logic [31:0] rdat;
  logic rerr;
  int np[9];
  int miscompares = 0;
  int n_tests = 0;
  // Each PWM row: control byte, counter, down flag, expected reference.
  logic [31:0] pwt[10] = '{32'h68000801, 32'h68002000, 32'h68001000, 32'h78002001, 32'h78000800,
    32'h68002010, 32'h68000811, 32'h68001011, 32'h78002011, 32'h78000810};
  logic [2:0] cm[5] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h0};
  logic cx[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  wire [8:0] pulses = {upd_o, chd_o, brk_o, cmt_o, chi_o, upi_o, psc_o, rld_o, clr_o};

  tmr_ch0_ctrl #(.CW(16)) uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .cen_i(cen_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cnt_i(cnt), .down_count_i(dcnt), .update_evt_i(1'b0),
    .trigger_edge_i(trg), .counter_clear_o(clr_o), .counter_reload_o(rld_o), .prescaler_clear_o(psc_o),
    .own_filtered_input_i(fin), .neighbour_filtered_input_i(1'b0), .internal_trigger_source_i(1'b0),
    .output_reference_o(ref_o), .main_output_o(main_o), .complementary_output_o(comp_o),
    .primary_output_enable_o(poe_o), .break_irq_o(brk_o), .cmt_irq_o(cmt_o), .ch0_irq_o(chi_o),
    .ch0_dma_o(chd_o), .update_irq_o(upi_o), .update_dma_o(upd_o));

  // The clock runs at 25 MHz.
  always #20 mclk_i = ~mclk_i;

  // Counting pulses catches both a missing pulse and one that sticks high.
  always @(posedge mclk_i) begin
    for (int i = 0; i < 9; i++) np[i] += (pulses[i] === 1'b1) ? 1 : 0;
  end

  task chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask

  task chk_bit(input logic g, input logic x);
    chk({31'h0, g}, {31'h0, x});
  endtask

  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // One APB transfer; the request is held until pready is seen at an edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("[FAIL] %0t no ready", $time);
    end
    rdat = prdata_o;
    rerr = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdat, x);
  endtask

  // Fire software events and expect each listed pulse exactly once.
  task evt(input logic [7:0] b, input logic [8:0] x);
    for (int i = 0; i < 9; i++) np[i] = 0;
    wr(OFF_SWEVG, {24'h0, b});
    cyc(5);
    for (int i = 0; i < 9; i++) chk(np[i], {31'h0, x[i]});
  endtask

  // Walk the counter off the value and back onto it to make a fresh match.
  task hit(input logic [15:0] v);
    cnt <= v + 16'h0001;
    cyc(2);
    cnt <= v;
    cyc(3);
  endtask

  task print_verdict;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // A hang is cut short long after the sequence should have ended.
  initial begin
    #800000;
    miscompares++;
    print_verdict();
  end

  initial begin
    cyc(16);
    rstn_i <= 1'b1;
    rd(OFF_SWEVG, 32'h0);
    rd(OFF_CTL0, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    wr(OFF_INTEN, 32'h3A3);
    evt(8'h00, 9'h000);
    evt(8'h01, 9'h10D);
    dcnt <= 1'b1;
    evt(8'h01, 9'h10E);
    dcnt <= 1'b0;
    rd(OFF_SWEVG, 32'h0);
    wr(OFF_FLAG, 32'h0);
    wr(OFF_CTL0, 32'h01);
    cnt <= 16'h1234;
    evt(8'h02, 9'h090);
    rd(OFF_CV, 32'h1234);
    rd(OFF_FLAG, 32'h002);
    cnt <= 16'h0042;
    evt(8'h02, 9'h090);
    rd(OFF_CV, 32'h0042);
    rd(OFF_FLAG, 32'h202);
    wr(OFF_CTL0, 32'h0);
    wr(OFF_FLAG, 32'h0);
    evt(8'h20, 9'h020);
    wr(OFF_CFG, 32'h1);
    cyc(2);
    chk_bit(poe_o, 1'b1);
    evt(8'h80, 9'h040);
    chk_bit(poe_o, 1'b0);
    rd(OFF_FLAG, 32'h0A0);
    // Forced levels seen through both polarities.
    wr(OFF_CFG, 32'h1);
    wr(OFF_CTL2, 32'h1);
    wr(OFF_CTL0, 32'h50);
    cyc(2);
    chk_bit(ref_o, 1'b1);
    chk_bit(main_o, 1'b1);
    wr(OFF_CTL2, 32'h3);
    cyc(2);
    chk_bit(main_o, 1'b0);
    wr(OFF_CTL0, 32'h40);
    cyc(2);
    chk_bit(ref_o, 1'b0);
    chk_bit(main_o, 1'b1);
    wr(OFF_CTL2, 32'h5);
    cyc(2);
    chk({30'h0, main_o, comp_o}, 32'h1);
    wr(OFF_CTL0, 32'h41);
    rd(OFF_CTL0, 32'h40);
    wr(OFF_CTL2, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTL0, m);
      rd(OFF_CTL0, m);
    end
    // Commutation with shadowed control loads the new mode only on the event.
    wr(OFF_CTL0, 32'h40);
    wr(OFF_CFG, 32'h9);
    wr(OFF_CTL0, 32'h50);
    cyc(2);
    chk_bit(ref_o, 1'b0);
    evt(8'h20, 9'h020);
    chk_bit(ref_o, 1'b1);
    wr(OFF_CFG, 32'h1);
    wr(OFF_CTL0, 32'h40);
    wr(OFF_CV, 32'h5);
    for (int i = 0; i < 5; i++) begin
      wr(OFF_CTL0, {25'h0, cm[i], 4'h0});
      hit(16'h0005);
      chk_bit(ref_o, cx[i]);
    end
    // With the shadow on, a new compare value waits for an update.
    wr(OFF_CTL0, 32'h48);
    wr(OFF_CV, 32'h9);
    wr(OFF_CTL0, 32'h18);
    hit(16'h0009);
    chk_bit(ref_o, 1'b0);
    cnt <= 16'h0000;
    evt(8'h01, 9'h10D);
    hit(16'h0009);
    chk_bit(ref_o, 1'b1);
    wr(OFF_CFG, 32'h7);
    wr(OFF_CTL0, 32'h60);
    rd(OFF_CTL0, 32'h18);
    wr(OFF_CTL0, 32'h19);
    wr(OFF_CTL0, 32'h61);
    rd(OFF_CTL0, 32'h61);
    wr(OFF_CTL0, 32'h60);
    wr(OFF_CFG, 32'h1);
    wr(OFF_CV, 32'h10);
    for (int i = 0; i < 10; i++) begin
      wr(OFF_CTL0, {24'h0, pwt[i][31:24]});
      cnt <= pwt[i][23:8];
      dcnt <= pwt[i][4];
      cyc(3);
      chk_bit(ref_o, pwt[i][0]);
    end
    // Fast path: a trigger edge forces the active level within three cycles.
    dcnt <= 1'b0;
    cnt <= 16'h0020;
    wr(OFF_CTL0, 32'h6C);
    cyc(3);
    chk_bit(ref_o, 1'b0);
    trg <= 1'b1;
    @(posedge mclk_i);
    trg <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk_bit(ref_o, 1'b0);
    @(posedge mclk_i);
    #1;
    chk_bit(ref_o, 1'b1);
    cyc(2);
    // With the clock enable low the reference must ignore a new comparison result.
    cen_i <= 1'b0;
    cnt <= 16'h0008;
    cyc(3);
    chk_bit(ref_o, 1'b0);
    cen_i <= 1'b1;
    cyc(3);
    chk_bit(ref_o, 1'b1);
    // A rising edge on the own input captures the counter once the channel is enabled.
    wr(OFF_CTL0, 32'h01);
    wr(OFF_CTL2, 32'h1);
    cnt <= 16'h0077;
    fin <= 1'b1;
    cyc(3);
    rd(OFF_CV, 32'h0077);
    print_verdict();
  end
endmodule

/* File: tmr_ch0_ctrl.sv */
// The APB register port was decided locally.
`timescale 1ns/1ns
// Function
// - Break bit drops output enable, flags, requests.
// - Commutation bit loads shadowed enables and mode.
// - Channel bit sets flag and sends requests.
// - Input mode captures counter, flags overcapture.
// - Update bit clears or reloads counter, prescaler.
// - Event bits self-clear after their event.
// - Codes 000-011 hold, set, clear, toggle.
// - Codes 100 and 101 force low, high.
// - PWM0 active below compare counting up.
// - PWM1 inactive below compare counting up.
// - PWM level follows the comparison every cycle.
// - Reference active high; polarity sets outputs.
// - Mode and shadow bits locked at full protection in output mode.
// - Shadowed compare value loads on update.
// - Fast enable treats trigger as match in the PWM modes.
// - Trigger to output three cycles when fast.
// - Mode field picks output or input source.
// - Trigger input mode needs internal trigger.
// - Mode field writable only while disabled.
// - Main polarity zero high, one low.
module tmr_ch0_ctrl
  import tmr_ch0_pkg::*;
#(
  parameter int CW = 16
) (
  // Clock, reset and enable.
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic cen_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Counter core.
  input wire logic [CW-1:0] cnt_i,
  input wire logic down_count_i,
  input wire logic update_evt_i,
  input wire logic trigger_edge_i,
  output logic counter_clear_o,
  output logic counter_reload_o,
  output logic prescaler_clear_o,
  // Channel inputs.
  input wire logic own_filtered_input_i,
  input wire logic neighbour_filtered_input_i,
  input wire logic internal_trigger_source_i,
  // Channel outputs.
  output logic output_reference_o,
  output logic main_output_o,
  output logic complementary_output_o,
  output logic primary_output_enable_o,
  // Request pulses.
  output logic break_irq_o,
  output logic cmt_irq_o,
  output logic ch0_irq_o,
  output logic ch0_dma_o,
  output logic update_irq_o,
  output logic update_dma_o
);

  // Counter width must fit the 16-bit register fields.
  if (CW < 2 || CW > 16) begin : g_bad_cw
    $error("CW must lie between 2 and 16");
  end

  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic brk_gen_q, cmt_gen_q, ch0_gen_q, upd_gen_q;
  logic clr_q, rld_q, psc_q;
  logic [9:0] inten_q, flag_q;
  logic outen_q, cmt_shadow_q, one_pulse_q;
  logic [1:0] lock_lvl_q;
  logic [2:0] trig_sel_q;
  chan_mode_t ms_q;
  cmp_mode_t com_q, com_pre_q;
  logic fen_q, sen_q;
  logic en_q, nen_q, en_pre_q, nen_pre_q, p_q, np_q;
  logic [CW-1:0] cv_q, cv_pre_q;
  logic ref_q, ref_d, match_q, sel_prev_q;
  logic [FAST_TRIG_CYC-2:0] trig_q;
  logic main_q, compl_q;
  logic brk_irq_q, cmt_irq_q, ch0_irq_q, ch0_dma_q, upd_irq_q, upd_dma_q;

  // Bus decode; a write takes effect only at the access edge with pready high.
  wire setup = psel_i & ~penable_i;
  wire acc = psel_i & penable_i & pready_q;
  wire wr = acc & pwrite_i;
  wire wr_inten = wr & (paddr_i == OFF_INTEN);
  wire wr_flag = wr & (paddr_i == OFF_FLAG);
  wire wr_swevg = wr & (paddr_i == OFF_SWEVG);
  wire wr_ctl0 = wr & (paddr_i == OFF_CTL0);
  wire wr_ctl2 = wr & (paddr_i == OFF_CTL2);
  wire wr_cv = wr & (paddr_i == OFF_CV);
  wire wr_cfg = wr & (paddr_i == OFF_CFG);
  wire mapped = (paddr_i == OFF_INTEN) | (paddr_i == OFF_FLAG) | (paddr_i == OFF_SWEVG) |
                (paddr_i == OFF_CTL0) | (paddr_i == OFF_CTL2) | (paddr_i == OFF_CNT) |
                (paddr_i == OFF_CV) | (paddr_i == OFF_CFG);

  // Protection locks the compare fields only while the channel is an output.
  wire cmp_lock = (lock_lvl_q == LOCK_FULL) & (ms_q == MS_OUT);
  wire pol_lock = lock_lvl_q[1];
  wire out_mode = (ms_q == MS_OUT);
  wire itrg_ok = (trig_sel_q <= TRIG_SEL_INT_MAX);
  wire is_pwm = (com_q == CMP_PWM0) | (com_q == CMP_PWM1);

  // Read data; the event generation register always reads zero.
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (paddr_i)
      OFF_INTEN: rdata[9:0] = inten_q;
      OFF_FLAG: rdata[9:0] = flag_q;
      OFF_SWEVG: rdata = 32'h0000_0000;
      OFF_CTL0: begin
        rdata[COM_LSB+:3] = com_q;
        rdata[SEN_BIT] = sen_q;
        rdata[FEN_BIT] = fen_q;
        rdata[MS_LSB+:2] = ms_q;
      end
      OFF_CTL2: rdata[3:0] = {np_q, nen_q, p_q, en_q};
      OFF_CNT: rdata[CW-1:0] = cnt_i;
      OFF_CV: rdata[CW-1:0] = cv_q;
      OFF_CFG: rdata[7:0] = {trig_sel_q, one_pulse_q, cmt_shadow_q, lock_lvl_q, outen_q};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Answer in the first access cycle: data is latched during setup.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (cen_i) begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= setup ? rdata : 32'h0000_0000;
    end
  end

  // Event bits are set by a write of one and fall back on the next edge.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      {brk_gen_q, cmt_gen_q, ch0_gen_q, upd_gen_q} <= 4'h0;
      {clr_q, rld_q, psc_q} <= 3'h0;
    end else if (cen_i) begin
      brk_gen_q <= wr_swevg & pwdata_i[EVG_BRK];
      cmt_gen_q <= wr_swevg & pwdata_i[EVG_CMT];
      ch0_gen_q <= wr_swevg & pwdata_i[EVG_CH0];
      upd_gen_q <= wr_swevg & pwdata_i[EVG_UPD];
      clr_q <= wr_swevg & pwdata_i[EVG_UPD] & ~down_count_i;
      rld_q <= wr_swevg & pwdata_i[EVG_UPD] & down_count_i;
      psc_q <= wr_swevg & pwdata_i[EVG_UPD];
    end
  end

  // Channel events from software, capture edges and compare matches.
  wire upd_evt = upd_gen_q | update_evt_i;
  logic sel_in;
  always_comb begin
    unique case (ms_q)
      MS_OWN: sel_in = own_filtered_input_i;
      MS_NEIGH: sel_in = neighbour_filtered_input_i;
      MS_ITRG: sel_in = internal_trigger_source_i & itrg_ok;
      MS_OUT: sel_in = 1'b0;
    endcase
  end
  wire sel_pol = sel_in ^ p_q;
  wire hw_cap = ~out_mode & en_q & sel_pol & ~sel_prev_q;
  wire capture = ~out_mode & (ch0_gen_q | hw_cap);
  wire match = (cnt_i == cv_q);
  wire match_rise = match & ~match_q;
  wire cmp_evt = out_mode & match_rise;
  wire ch0_evt = ch0_gen_q | hw_cap | cmp_evt;

  // Flags: write zero clears, a hardware set in the same cycle wins.
  logic [9:0] flag_set;
  always_comb begin
    flag_set = 10'h000;
    flag_set[F_UPD] = upd_evt;
    flag_set[F_CH0] = ch0_evt;
    flag_set[F_CMT] = cmt_gen_q;
    flag_set[F_BRK] = brk_gen_q;
    flag_set[F_OVC] = capture & flag_q[F_CH0];
  end
  wire [9:0] flag_clr = wr_flag ? ~pwdata_i[9:0] : 10'h000;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      flag_q <= 10'h000;
      inten_q <= 10'h000;
    end else if (cen_i) begin
      flag_q <= ((flag_q & ~flag_clr) | flag_set) & FLAG_MASK;
      if (wr_inten) begin
        inten_q <= pwdata_i[9:0] & INTEN_MASK;
      end
    end
  end

  // Configuration; the break event overrides a write of the output enable.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      {outen_q, cmt_shadow_q, one_pulse_q} <= 3'h0;
      lock_lvl_q <= 2'h0;
      trig_sel_q <= 3'h0;
    end else if (cen_i) begin
      if (wr_cfg) begin
        outen_q <= pwdata_i[OUTEN_BIT];
        lock_lvl_q <= pwdata_i[LOCK_LSB+:2];
        cmt_shadow_q <= pwdata_i[CMT_SHADOW_BIT];
        one_pulse_q <= pwdata_i[ONE_PULSE_BIT];
        trig_sel_q <= pwdata_i[TRIG_SEL_LSB+:3];
      end
      if (brk_gen_q) begin
        outen_q <= 1'b0;
      end
    end
  end

  // Channel control 0; with commutation shadowing the mode goes to a preload copy.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ms_q <= MS_OUT;
      com_q <= CMP_TIMING;
      com_pre_q <= CMP_TIMING;
      {fen_q, sen_q} <= 2'h0;
    end else if (cen_i) begin
      if (wr_ctl0) begin
        fen_q <= pwdata_i[FEN_BIT];
        if (!en_q) begin
          ms_q <= chan_mode_t'(pwdata_i[MS_LSB+:2]);
        end
        if (!cmp_lock) begin
          sen_q <= pwdata_i[SEN_BIT];
          com_pre_q <= cmp_mode_t'(pwdata_i[COM_LSB+:3]);
          if (!cmt_shadow_q) begin
            com_q <= cmp_mode_t'(pwdata_i[COM_LSB+:3]);
          end
        end
      end else if (cmt_gen_q && cmt_shadow_q) begin
        com_q <= com_pre_q;
      end
    end
  end

  // Channel control 2; polarity is frozen at protection levels 10 and 11.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      {en_q, nen_q, en_pre_q, nen_pre_q, p_q, np_q} <= 6'h00;
    end else if (cen_i) begin
      if (wr_ctl2) begin
        en_pre_q <= pwdata_i[EN_BIT];
        nen_pre_q <= pwdata_i[NEN_BIT];
        if (!cmt_shadow_q) begin
          en_q <= pwdata_i[EN_BIT];
          nen_q <= pwdata_i[NEN_BIT];
        end
        if (!pol_lock) begin
          p_q <= pwdata_i[P_BIT];
          np_q <= pwdata_i[NP_BIT];
        end
      end else if (cmt_gen_q && cmt_shadow_q) begin
        en_q <= en_pre_q;
        nen_q <= nen_pre_q;
      end
    end
  end

  // Compare value: direct or shadowed, and also the capture register.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cv_q <= RST16[CW-1:0];
      cv_pre_q <= RST16[CW-1:0];
    end else if (cen_i) begin
      if (wr_cv) begin
        cv_pre_q <= pwdata_i[CW-1:0];
      end
      if (capture) begin
        cv_q <= cnt_i;
      end else if (wr_cv && !sen_q) begin
        cv_q <= pwdata_i[CW-1:0];
      end else if (upd_evt && sen_q && out_mode) begin
        cv_q <= cv_pre_q;
      end
    end
  end

  // Reference level. Compare modes act on the first cycle of a match so that a
  // slow prescaler holding the counter does not toggle the output repeatedly.
  wire fast_fire = fen_q & is_pwm & trig_q[FAST_TRIG_CYC-2];
  wire pwm0_lvl = down_count_i ? (cnt_i <= cv_q) : (cnt_i < cv_q);
  wire pwm1_lvl = down_count_i ? (cnt_i > cv_q) : (cnt_i >= cv_q);
  always_comb begin
    ref_d = ref_q;
    unique case (com_q)
      CMP_TIMING: ref_d = ref_q;
      CMP_SET: ref_d = match_rise ? 1'b1 : ref_q;
      CMP_CLEAR: ref_d = match_rise ? 1'b0 : ref_q;
      CMP_TOGGLE: ref_d = match_rise ? ~ref_q : ref_q;
      CMP_LOW: ref_d = 1'b0;
      CMP_HIGH: ref_d = 1'b1;
      CMP_PWM0: ref_d = fast_fire | pwm0_lvl;
      CMP_PWM1: ref_d = fast_fire | pwm1_lvl;
    endcase
    if (!out_mode) begin
      ref_d = 1'b0;
    end
  end

  // Outputs follow the reference through polarity and the enables.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      {ref_q, match_q, sel_prev_q, main_q, compl_q} <= 5'h00;
      trig_q <= '0;
    end else if (cen_i) begin
      ref_q <= ref_d;
      match_q <= match;
      sel_prev_q <= sel_pol;
      trig_q <= {trig_q[FAST_TRIG_CYC-3:0], trigger_edge_i};
      main_q <= out_mode & en_q & outen_q & (ref_d ^ p_q);
      compl_q <= out_mode & nen_q & outen_q & (~ref_d ^ np_q);
    end
  end

  // Request pulses, gated by their enables.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      {brk_irq_q, cmt_irq_q, ch0_irq_q, ch0_dma_q, upd_irq_q, upd_dma_q} <= 6'h00;
    end else if (cen_i) begin
      brk_irq_q <= brk_gen_q & inten_q[F_BRK];
      cmt_irq_q <= cmt_gen_q & inten_q[F_CMT];
      ch0_irq_q <= ch0_evt & inten_q[F_CH0];
      ch0_dma_q <= ch0_evt & inten_q[DE_CH0];
      upd_irq_q <= upd_evt & inten_q[F_UPD];
      upd_dma_q <= upd_evt & inten_q[DE_UPD];
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign counter_clear_o = clr_q;
  assign counter_reload_o = rld_q;
  assign prescaler_clear_o = psc_q;
  assign output_reference_o = ref_q;
  assign main_output_o = main_q;
  assign complementary_output_o = compl_q;
  assign primary_output_enable_o = outen_q;
  assign break_irq_o = brk_irq_q;
  assign cmt_irq_o = cmt_irq_q;
  assign ch0_irq_o = ch0_irq_q;
  assign ch0_dma_o = ch0_dma_q;
  assign update_irq_o = upd_irq_q;
  assign update_dma_o = upd_dma_q;

  // Checks on the documented behaviour.
  chk_break_primary_output_enable_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (wr_swevg && pwdata_i[EVG_BRK] && cen_i) ##1 cen_i |=> (!outen_q && flag_q[F_BRK]))
    else $error("break event did not clear enable or set flag");
  chk_event_selfclear: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ch0_gen_q && cen_i && !wr_swevg) |=> !ch0_gen_q)
    else $error("channel event bit did not self clear");
  chk_swevg_reads_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (pready_o && psel_i && penable_i && !pwrite_i && paddr_i == OFF_SWEVG) |-> prdata_o == 32'h0000_0000)
    else $error("event register read nonzero");
  chk_force_high: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (cen_i && out_mode && com_q == CMP_HIGH) |=> output_reference_o)
    else $error("forced high reference not high");
  chk_protection_level_locks_sen: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (wr_ctl0 && cmp_lock && cen_i) |=> sen_q == $past(sen_q))
    else $error("shadow enable changed while protected");
  chk_mode_locked_en: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (wr_ctl0 && en_q) |=> $stable(ms_q))
    else $error("mode field changed while channel enabled");
  chk_fast_trigger: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (trigger_edge_i && cen_i && fen_q && out_mode && com_q == CMP_PWM0) ##1 (cen_i && !wr)[*2]
    |=> output_reference_o)
    else $error("fast trigger did not set reference in three cycles");
  chk_sw_capture: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ch0_gen_q && !out_mode && cen_i) |=> (cv_q == $past(cnt_i) && flag_q[F_CH0]))
    else $error("software capture did not store counter");
  chk_overcapture: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ch0_gen_q && !out_mode && flag_q[F_CH0] && cen_i) |=> flag_q[F_OVC])
    else $error("overcapture flag not set");
  chk_shadow_load: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (upd_evt && sen_q && out_mode && cen_i && !wr_cv) |=> cv_q == $past(cv_pre_q))
    else $error("shadow compare value not loaded on update");
  cov_break: cover property (@(posedge mclk_i) disable iff (!rstn_i) brk_irq_q);
  cov_pwm_fast: cover property (@(posedge mclk_i) disable iff (!rstn_i) fast_fire && cen_i);
  cov_capture_over: cover property (@(posedge mclk_i) disable iff (!rstn_i) flag_set[F_OVC] && cen_i);
endmodule

/* File: tmr_ch0_pkg.sv */
package tmr_ch0_pkg;
  // Register byte offsets on the APB word map.
  localparam logic [7:0] OFF_INTEN = 8'h0C;
  localparam logic [7:0] OFF_FLAG = 8'h10;
  localparam logic [7:0] OFF_SWEVG = 8'h14;
  localparam logic [7:0] OFF_CTL0 = 8'h18;
  localparam logic [7:0] OFF_CTL2 = 8'h20;
  localparam logic [7:0] OFF_CNT = 8'h24;
  localparam logic [7:0] OFF_CV = 8'h34;
  localparam logic [7:0] OFF_CFG = 8'h40;
  // Event generation bit positions.
  localparam int EVG_UPD = 0;
  localparam int EVG_CH0 = 1;
  localparam int EVG_CMT = 5;
  localparam int EVG_BRK = 7;
  // Flag and enable bit positions; DMA enables sit at 8 and 9.
  localparam int F_UPD = 0;
  localparam int F_CH0 = 1;
  localparam int F_CMT = 5;
  localparam int F_BRK = 7;
  localparam int F_OVC = 9;
  localparam int DE_UPD = 8;
  localparam int DE_CH0 = 9;
  localparam logic [9:0] FLAG_MASK = 10'h2A3;
  localparam logic [9:0] INTEN_MASK = 10'h3A3;
  // Channel control 0 fields.
  localparam int MS_LSB = 0;
  localparam int FEN_BIT = 2;
  localparam int SEN_BIT = 3;
  localparam int COM_LSB = 4;
  // Channel control 2 fields.
  localparam int EN_BIT = 0;
  localparam int P_BIT = 1;
  localparam int NEN_BIT = 2;
  localparam int NP_BIT = 3;
  // Configuration register fields.
  localparam int OUTEN_BIT = 0;
  localparam int LOCK_LSB = 1;
  localparam int CMT_SHADOW_BIT = 3;
  localparam int ONE_PULSE_BIT = 4;
  localparam int TRIG_SEL_LSB = 5;
  localparam logic [1:0] LOCK_FULL = 2'h3;
  localparam logic [2:0] TRIG_SEL_INT_MAX = 3'h3;
  // Trigger to output delay with fast enable set, in clock cycles.
  localparam int FAST_TRIG_CYC = 3;
  localparam int SLOW_TRIG_CYC = 5;
  localparam logic [15:0] RST16 = 16'h0000;

  typedef enum logic [1:0] {
    MS_OUT = 2'b00,
    MS_OWN = 2'b01,
    MS_NEIGH = 2'b10,
    MS_ITRG = 2'b11
  } chan_mode_t;

  typedef enum logic [2:0] {
    CMP_TIMING = 3'b000,
    CMP_SET = 3'b001,
    CMP_CLEAR = 3'b010,
    CMP_TOGGLE = 3'b011,
    CMP_LOW = 3'b100,
    CMP_HIGH = 3'b101,
    CMP_PWM0 = 3'b110,
    CMP_PWM1 = 3'b111
  } cmp_mode_t;
endpackage
